// ---- logic/audio_mixer_meter.sv ----
// Audio group mixer, gain, routing and peak/VU meter with AXI4-Lite control
`include "audio_mixer_regs.svh"

module audio_mixer_meter (
  // Clock and reset
  input  wire logic                          MCLK,
  input  wire logic                          RST_B,
  // AXI4-Lite slave
  input  wire logic [`AW-1:0]                AWADDR,
  input  wire logic                          AWVALID,
  output logic                               AWREADY,
  input  wire logic [31:0]                   WDATA,
  input  wire logic [3:0]                    WSTRB,
  input  wire logic                          WVALID,
  output logic                               WREADY,
  output logic [1:0]                         BRESP,
  output logic                               BVALID,
  input  wire logic                          BREADY,
  input  wire logic [`AW-1:0]                ARADDR,
  input  wire logic                          ARVALID,
  output logic                               ARREADY,
  output logic [31:0]                        RDATA,
  output logic [1:0]                         RRESP,
  output logic                               RVALID,
  input  wire logic                          RREADY,
  // Receiver status pins
  input  wire logic                          SDI_LOCK,
  input  wire logic                          SDI_IS625,
  input  wire logic [3:0]                    GRP_PRESENT,
  // Audio from the receiver, same clock
  input  wire audio_mixer_pkg::audio_frame_t AUD_IN,
  output logic [1:0]                         GROUP_SEL,
  // Audio to the DACs and indicators
  output audio_mixer_pkg::audio_frame_t      AUD_OUT,
  output audio_mixer_pkg::meter_t [3:0]      METER,
  output logic                               SETUP_EN,
  output logic                               DIG_REF_SEL,
  output logic                               ANLG_REF_SEL,
  output logic                               IRQ
);

  // Pin synchronisers
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end else begin
      pin_meta_r <= {GRP_PRESENT, SDI_IS625, SDI_LOCK};
      pin_sync_r <= pin_meta_r;
    end
  end
  wire       lock_s = pin_sync_r[0];
  wire       is625_s = pin_sync_r[1];
  wire [3:0] present_s = pin_sync_r[5:2];

  // Control registers
  logic [7:0]       config_r;
  logic [3:0][7:0]  gain_r;
  logic [15:0]      route_r;
  logic [5:0]       ctrl_r;
  logic [5:0]       irq_stat_r;
  logic [5:0]       irq_en_r;

  wire [1:0] grp_sel = config_r[`CFG_GRP_LSB +: 2];
  wire [2:0] hdrm    = config_r[`CFG_HDRM_LSB +: 3];
  wire       dref    = config_r[`CFG_DREF_BIT];
  wire       aref    = config_r[`CFG_AREF_BIT];
  wire [3:0] invert  = ctrl_r[`CTRL_INV_LSB +: 4];
  wire       tie12   = ctrl_r[`CTRL_TIE12_BIT];
  wire       tie34   = ctrl_r[`CTRL_TIE34_BIT];

  // Status derived from the synchronised pins
  audio_mixer_pkg::presence_t presence;
  assign presence = !lock_s ? audio_mixer_pkg::PRES_NONE :
                    is625_s ? audio_mixer_pkg::PRES_625 :
                              audio_mixer_pkg::PRES_525;
  wire audio_valid = lock_s && present_s[grp_sel];

  // Tied pairs take the lower channel's gain
  logic [3:0][7:0] gain_eff;
  assign gain_eff[0] = gain_r[0];
  assign gain_eff[1] = tie12 ? gain_r[0] : gain_r[1];
  assign gain_eff[2] = gain_r[2];
  assign gain_eff[3] = tie34 ? gain_r[2] : gain_r[3];

  // AXI4-Lite write path
  logic        aw_free_r;
  logic        w_free_r;
  logic        bvalid_r;
  logic [`AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire aw_take = AWVALID && aw_free_r;
  wire w_take  = WVALID && w_free_r;
  wire wr_go   = !aw_free_r && !w_free_r && !bvalid_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                       {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits = wdata_r & wmask;
  wire [`AW-1:0] wa = awaddr_r;
  wire wr_cfg   = wr_go && wa == `OFS_CONFIG;
  wire wr_route = wr_go && wa == `OFS_ROUTE;
  wire wr_ctrl  = wr_go && wa == `OFS_CTRL;
  wire wr_dflt  = wr_go && wa == `OFS_DEFAULT;
  wire wr_clr   = wr_go && wa == `OFS_IRQ_CLR;
  wire wr_en    = wr_go && wa == `OFS_IRQ_EN;
  wire wr_gain  = wr_go && wa >= `OFS_GAIN0 && wa <= `OFS_GAIN3;
  wire [1:0] gidx = 2'(wa[`AW-1:2] - 4'h2);
  wire wa_known = wr_cfg || wr_route || wr_ctrl || wr_dflt || wr_clr ||
                  wr_en || wr_gain || wa == `OFS_STATUS ||
                  wa == `OFS_IRQ_STAT || wa == `OFS_METER;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Out-of-range gain requests clamp to the end stops
  wire [7:0] gain_req = 8'(merge(32'(gain_r[gidx]), wdata_r, wmask));
  wire signed [7:0] gain_sreq = signed'(gain_req);
  wire [7:0] gain_clamp =
    gain_sreq > `GAIN_MAX_DB ? `GAIN_MAX_DB :
    gain_sreq < `GAIN_MIN_DB ? 8'(`GAIN_MIN_DB) : gain_req;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_free_r <= 1'b1;
      w_free_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      BRESP     <= 2'h0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_free_r <= 1'b0;
        awaddr_r  <= AWADDR;
      end
      if (w_take) begin
        w_free_r <= 1'b0;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
      end
      if (wr_go) begin
        bvalid_r  <= 1'b1;
        BRESP     <= wa_known ? 2'h0 : 2'h2;
      end else if (BREADY && bvalid_r) begin
        bvalid_r  <= 1'b0;
        aw_free_r <= 1'b1;
        w_free_r  <= 1'b1;
      end
    end
  end
  assign AWREADY = aw_free_r;
  assign WREADY  = w_free_r;
  assign BVALID  = bvalid_r;

  // Register updates
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      config_r <= `RST_CONFIG;
      route_r  <= `RST_ROUTE;
      ctrl_r   <= `RST_CTRL;
      irq_en_r <= 6'h00;
    end else begin
      if (wr_cfg)
        config_r <= 8'(merge(32'(config_r), wdata_r, wmask));
      if (wr_route)
        route_r <= 16'(merge(32'(route_r), wdata_r, wmask));
      if (wr_ctrl)
        ctrl_r <= 6'(merge(32'(ctrl_r), wdata_r, wmask));
      if (wr_en)
        irq_en_r <= 6'(merge(32'(irq_en_r), wdata_r, wmask));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gain
      always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B)
          gain_r[gi] <= `RST_GAIN;
        else if (wr_dflt && wbits[gi])
          gain_r[gi] <= `RST_GAIN;
        else if (wr_gain && gidx == 2'(gi))
          gain_r[gi] <= gain_clamp;
      end
    end
  endgenerate

  // Gain: 6 dB per octave shift times a one-sixth-step fraction
  function automatic logic [16:0] frac_gain(input logic [2:0] r);
    case (r)
      3'h0:    frac_gain = 17'h08000;
      3'h1:    frac_gain = 17'h08FAD;
      3'h2:    frac_gain = 17'h0A145;
      3'h3:    frac_gain = 17'h0B4CE;
      3'h4:    frac_gain = 17'h0CADE;
      3'h5:    frac_gain = 17'h0E38E;
      default: frac_gain = 17'h08000;
    endcase
  endfunction

  function automatic logic signed [23:0] sat24(input logic signed [63:0] v);
    if (v > 64'sh7FFFFF)
      sat24 = 24'sh7FFFFF;
    else if (v < -64'sh7FFFFF)
      sat24 = -24'sh7FFFFF;
    else
      sat24 = 24'(v);
  endfunction

  function automatic logic signed [63:0] scale(input logic signed [23:0] s,
                                               input logic [7:0] db,
                                               input logic inv);
    logic [6:0]         ofs;
    logic [3:0]         oct;
    logic [2:0]         step;
    logic signed [63:0] p;
    ofs  = 7'(db + `GAIN_OFS_DB);
    oct  = 4'(ofs / `GAIN_STEP_DB);
    step = 3'(ofs % `GAIN_STEP_DB);
    p = 64'(s) * signed'(64'(frac_gain(step)));
    p = (p <<< oct) >>> `GAIN_FRAC_BITS;
    scale = inv ? -p : p;
  endfunction

  // Stage 1: per-input gain and polarity on the selected group
  // Named element type keeps each sample signed when the sums extend it
  audio_mixer_pkg::sample_t [3:0] scaled_r;
  logic                           s1_valid_r;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_scale
      always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B)
          scaled_r[gi] <= 24'sh000000;
        else if (AUD_IN.valid)
          scaled_r[gi] <= sat24(scale(AUD_IN.ch[gi], gain_eff[gi],
                                      invert[gi]));
      end
    end
  endgenerate

  // Stage 2: routed sums, saturated rather than wrapped
  logic signed [3:0][23:0] mix;
  logic [3:0]              peak_hit;
  audio_mixer_pkg::meter_t [3:0] meter_nxt;
  logic [23:0] thr_peak;
  wire  [23:0] vu0   = dref ? `VU0_REF18 : `VU0_REF20;
  wire  [23:0] vum20 = dref ? `VUM20_REF18 : `VUM20_REF20;

  always_comb begin
    case (hdrm)
      3'h1:    thr_peak = `THR_HDRM_2DB;
      3'h2:    thr_peak = `THR_HDRM_4DB;
      3'h3:    thr_peak = `THR_HDRM_6DB;
      3'h4:    thr_peak = `THR_HDRM_8DB;
      3'h5:    thr_peak = `THR_HDRM_10DB;
      default: thr_peak = `FULL_SCALE;
    endcase
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_mix
      wire signed [63:0] sum =
        (route_r[gi]      ? 64'(scaled_r[0]) : 64'sh0) +
        (route_r[4 + gi]  ? 64'(scaled_r[1]) : 64'sh0) +
        (route_r[8 + gi]  ? 64'(scaled_r[2]) : 64'sh0) +
        (route_r[12 + gi] ? 64'(scaled_r[3]) : 64'sh0);
      assign mix[gi] = lock_s ? sat24(sum) : 24'sh000000;
      wire [23:0] mag = mix[gi][23] ? 24'(-mix[gi]) : mix[gi];
      assign peak_hit[gi]         = mag >= thr_peak;
      assign meter_nxt[gi].peak   = peak_hit[gi];
      assign meter_nxt[gi].orange = mag > vu0;
      assign meter_nxt[gi].green  = mag > vum20 && mag <= vu0;
    end
  endgenerate

  audio_mixer_pkg::audio_frame_t out_r;
  audio_mixer_pkg::meter_t [3:0] meter_r;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_valid_r <= 1'b0;
      out_r      <= '0;
      meter_r    <= '0;
    end else begin
      s1_valid_r  <= AUD_IN.valid;
      out_r.valid <= s1_valid_r;
      if (s1_valid_r) begin
        out_r.ch <= mix;
        meter_r  <= meter_nxt;
      end
    end
  end
  assign AUD_OUT = out_r;
  assign METER   = meter_r;

  // Control outputs to receiver and analog stages
  logic [1:0] group_out_r;
  logic       setup_r;
  logic       dref_r;
  logic       aref_r;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      group_out_r <= 2'h0;
      setup_r     <= 1'b0;
      dref_r      <= 1'b0;
      aref_r      <= 1'b0;
    end else begin
      group_out_r <= grp_sel;
      setup_r     <= config_r[`CFG_SETUP_BIT] &&
                     presence == audio_mixer_pkg::PRES_525;
      dref_r      <= dref;
      aref_r      <= aref;
    end
  end
  assign GROUP_SEL    = group_out_r;
  assign SETUP_EN     = setup_r;
  assign DIG_REF_SEL  = dref_r;
  assign ANLG_REF_SEL = aref_r;

  // Interrupt status: lock change, audio-valid change, per-channel peak
  logic lock_d_r;
  logic aval_d_r;
  logic irq_r;
  wire [5:0] irq_ev = {peak_hit & {4{s1_valid_r}},
                       audio_valid != aval_d_r, lock_s != lock_d_r};
  wire [5:0] irq_clr = wr_clr ? wbits[5:0] : 6'h00;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_d_r   <= 1'b0;
      aval_d_r   <= 1'b0;
      irq_stat_r <= 6'h00;
      irq_r      <= 1'b0;
    end else begin
      lock_d_r   <= lock_s;
      aval_d_r   <= audio_valid;
      // A new event wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq_r      <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
    end
  end
  assign IRQ = irq_r;

  // AXI4-Lite read path
  logic        ar_free_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ARADDR)
      `OFS_CONFIG:   rd_mux = 32'(config_r);
      `OFS_STATUS:   rd_mux = {27'h0, audio_valid, grp_sel, presence};
      `OFS_GAIN0:    rd_mux = {{24{gain_eff[0][7]}}, gain_eff[0]};
      `OFS_GAIN1:    rd_mux = {{24{gain_eff[1][7]}}, gain_eff[1]};
      `OFS_GAIN2:    rd_mux = {{24{gain_eff[2][7]}}, gain_eff[2]};
      `OFS_GAIN3:    rd_mux = {{24{gain_eff[3][7]}}, gain_eff[3]};
      `OFS_ROUTE:    rd_mux = 32'(route_r);
      `OFS_CTRL:     rd_mux = 32'(ctrl_r);
      `OFS_DEFAULT:  rd_mux = 32'h0;
      `OFS_IRQ_STAT: rd_mux = 32'(irq_stat_r);
      `OFS_IRQ_CLR:  rd_mux = 32'h0;
      `OFS_IRQ_EN:   rd_mux = 32'(irq_en_r);
      `OFS_METER:    rd_mux = 32'(meter_r);
      default: begin
        rd_mux = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ar_free_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= 2'h0;
    end else if (ARVALID && ar_free_r) begin
      ar_free_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_ok ? 2'h0 : 2'h2;
    end else if (RREADY && rvalid_r) begin
      ar_free_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end
  assign ARREADY = ar_free_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;

  // Checks
  mute_on_loss_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !lock_s && s1_valid_r |=> AUD_OUT.ch == '0)
    else $error("audio not muted without lock");

  setup_gate_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    SETUP_EN |-> $past(presence) == audio_mixer_pkg::PRES_525)
    else $error("setup active outside 525");

  pipe_latency_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    AUD_IN.valid |-> ##2 AUD_OUT.valid)
    else $error("output valid not two cycles after input");

  group_follow_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_cfg |-> ##2 GROUP_SEL == $past(config_r[1:0]))
    else $error("group select not driven out");

  presence_code_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    presence != audio_mixer_pkg::PRES_NONE |-> lock_s)
    else $error("presence reported without lock");

  gain_range_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    signed'(gain_r[gidx]) <= `GAIN_MAX_DB &&
    signed'(gain_r[gidx]) >= `GAIN_MIN_DB)
    else $error("gain outside range");

  tie_share_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    tie12 |-> gain_eff[1] == gain_eff[0])
    else $error("tied pair gains differ");

  default_unity_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_dflt && wbits[0] |=> gain_r[0] == 8'h00)
    else $error("default did not restore unity");

  peak_meter_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    s1_valid_r && peak_hit[0] |=> METER[0].peak ##0 irq_stat_r[2])
    else $error("peak not flagged");

  vu_exclusive_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(METER[1].orange && METER[1].green))
    else $error("orange and green together");

endmodule

// ---- logic/audio_mixer_pkg.sv ----
// Types shared by the audio mixer and meter
package audio_mixer_pkg;
  typedef logic signed [23:0] sample_t;

  typedef struct packed {
    logic             valid;
    sample_t [3:0]    ch;
  } audio_frame_t;

  typedef struct packed {
    logic peak;
    logic orange;
    logic green;
  } meter_t;

  typedef enum logic [1:0] {
    PRES_NONE = 2'h0,
    PRES_525  = 2'h1,
    PRES_625  = 2'h2
  } presence_t;
endpackage

// ---- logic/audio_mixer_regs.svh ----
// Register map, field positions, reset values and level constants
`ifndef AUDIO_MIXER_REGS_SVH
`define AUDIO_MIXER_REGS_SVH

`define AW                 6
`define OFS_CONFIG         6'h00
`define OFS_STATUS         6'h04
`define OFS_GAIN0          6'h08
`define OFS_GAIN1          6'h0C
`define OFS_GAIN2          6'h10
`define OFS_GAIN3          6'h14
`define OFS_ROUTE          6'h18
`define OFS_CTRL           6'h1C
`define OFS_DEFAULT        6'h20
`define OFS_IRQ_STAT       6'h24
`define OFS_IRQ_CLR        6'h28
`define OFS_IRQ_EN         6'h2C
`define OFS_METER          6'h30

`define CFG_GRP_LSB        0
`define CFG_SETUP_BIT      2
`define CFG_HDRM_LSB       3
`define CFG_DREF_BIT       6
`define CFG_AREF_BIT       7
`define CTRL_INV_LSB       0
`define CTRL_TIE12_BIT     4
`define CTRL_TIE34_BIT     5

`define RST_CONFIG         8'h00
`define RST_GAIN           8'h00
`define RST_ROUTE          16'h8421
`define RST_CTRL           6'h00

`define GAIN_MAX_DB        8'sh0C
`define GAIN_MIN_DB        -8'sh46
`define GAIN_OFS_DB        8'h48
`define GAIN_STEP_DB       7'h06
`define GAIN_FRAC_BITS     27

`define FULL_SCALE         24'h7FFFFF
`define THR_HDRM_2DB       24'h65ACDE
`define THR_HDRM_4DB       24'h50C312
`define THR_HDRM_6DB       24'h4026E6
`define THR_HDRM_8DB       24'h32F52B
`define THR_HDRM_10DB      24'h287A03
`define VU0_REF20          24'h0CCCCD
`define VU0_REF18          24'h101D44
`define VUM20_REF20        24'h0147AE
`define VUM20_REF18        24'h019C87

`endif

// ---- sim/audio_mixer_meter_bench.sv ----
// Self-checking bench for the audio group mixer and meter
`include "audio_mixer_regs.svh"
module audio_mixer_meter_bench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  g0;
    logic [15:0] rt;
    logic [7:0]  ct;
    logic [23:0] in0;
    logic [95:0] o;
    logic [2:0]  m;
  } row_t;

  logic                                 MCLK, AWREADY, WREADY, BVALID;
  logic                                 RST_B = 1'b0, AWVALID = 1'b0;
  logic                                 WVALID = 1'b0, BREADY = 1'b0;
  logic                                 ARVALID = 1'b0, RREADY = 1'b0;
  logic                                 SDI_LOCK = 1'b1, SDI_IS625 = 1'b0;
  logic                                 send = 1'b0, ARREADY, RVALID;
  logic                                 SETUP_EN, DIG_REF_SEL, ANLG_REF_SEL;
  logic                                 IRQ;
  logic [5:0]                           AWADDR = '0, ARADDR = '0;
  logic [31:0]                          WDATA = '0, RDATA;
  logic [3:0]                           WSTRB = 4'hF, GRP_PRESENT = 4'h5;
  logic [1:0]                           BRESP, RRESP, GROUP_SEL;
  audio_mixer_pkg::audio_frame_t        AUD_IN, AUD_OUT;
  audio_mixer_pkg::meter_t [3:0]        METER;
  audio_mixer_pkg::sample_t [3:0]       smp = '0;
  row_t                                 rows [18];
  int                                   mismatches = 0, check_count = 0;

  audio_mixer_meter uut (.MCLK, .RST_B, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .SDI_LOCK,
    .SDI_IS625, .GRP_PRESENT, .AUD_IN, .GROUP_SEL, .AUD_OUT, .METER,
    .SETUP_EN, .DIG_REF_SEL, .ANLG_REF_SEL, .IRQ);

  sdi_rx_model rx (.clk(MCLK), .rst_b(RST_B), .grp_sel(GROUP_SEL),
    .send(send), .smp(smp), .aud(AUD_IN));

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    chk({BVALID, BRESP}, {1'b1, er});
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    chk({RVALID, RRESP, RDATA}, {1'b1, er, e});
  endtask

  // Channels 2..4 stay fixed so routing sums are easy to predict
  task automatic aud(input logic [23:0] x, input logic [95:0] e,
                     input logic v = 1'b1);
    int n;
    n = 0;
    @(posedge MCLK);
    smp <= {24'h000400, 24'h000300, 24'h000200, x};
    send <= 1'b1;
    @(posedge MCLK);
    send <= 1'b0;
    do begin
      @(posedge MCLK);
      n++;
    end while (AUD_OUT.valid !== 1'b1 && n < 8);
    if (v) chk(AUD_OUT.valid, 1'b1);
    chk(AUD_OUT.ch, e);
  endtask

  initial begin
    #100000;
    mismatches++;
    summarize();
  end

  initial begin
    rows = '{
      '{8'h00,8'h06,16'h8421,8'h00,24'h000100,96'h400000300000200000200,3'h0},
      '{8'h00,8'h00,16'h000F,8'h00,24'h000100,96'h100000100000100000100,3'h0},
      '{8'h00,8'h00,16'hFFFF,8'h00,24'h000100,96'hA00000A00000A00000A00,3'h0},
      '{8'h00,8'h00,16'h0000,8'h00,24'h000100,96'h0,3'h0},
      '{8'h00,8'h00,16'h8421,8'h01,24'h000100,96'h400000300000200FFFF00,3'h0},
      '{8'h00,8'h06,16'h8421,8'h10,24'h000100,96'h400000300000400000200,3'h0},
      '{8'h00,8'h00,16'h8421,8'h00,24'h020000,96'h400000300000200020000,3'h1},
      '{8'h00,8'h00,16'h8421,8'h00,24'h0E0000,96'h4000003000002000E0000,3'h2},
      '{8'h40,8'h00,16'h8421,8'h00,24'h0E0000,96'h4000003000002000E0000,3'h1},
      '{8'h08,8'h00,16'h8421,8'h00,24'h700000,96'h400000300000200700000,3'h6},
      '{8'h38,8'h00,16'h8421,8'h00,24'h700000,96'h400000300000200700000,3'h2},
      '{8'h10,8'h00,16'h8421,8'h00,24'h50C312,96'h40000030000020050C312,3'h6},
      '{8'h18,8'h00,16'h8421,8'h00,24'h4026E5,96'h4000003000002004026E5,3'h2},
      '{8'h20,8'h00,16'h8421,8'h00,24'h32F52A,96'h40000030000020032F52A,3'h2},
      '{8'h28,8'h00,16'h8421,8'h00,24'h300000,96'h400000300000200300000,3'h6},
      '{8'h00,8'h0C,16'h8421,8'h00,24'h7FFFFF,96'h4000003000002007FFFFF,3'h6},
      '{8'h00,8'h00,16'h8421,8'h01,24'h7FFFFF,96'h400000300000200800001,3'h6},
      '{8'h00,8'h00,16'h8421,8'h00,24'h000100,96'h400000300000200000100,3'h0}};
    repeat (16) @(posedge MCLK);
    RST_B <= 1'b1;
    rd(`OFS_CONFIG, 32'h0);
    rd(`OFS_GAIN0, 32'h0);
    rd(`OFS_ROUTE, 32'h8421);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_IRQ_EN, 32'h0);
    foreach (rows[i]) begin
      wr(`OFS_CONFIG, {24'h0, rows[i].cfg});
      wr(`OFS_GAIN0, {24'h0, rows[i].g0});
      wr(`OFS_ROUTE, {16'h0, rows[i].rt});
      wr(`OFS_CTRL, {24'h0, rows[i].ct});
      aud(rows[i].in0, rows[i].o);
      chk(METER[0], rows[i].m);
    end
    rd(`OFS_STATUS, 32'h11);
    wr(`OFS_CONFIG, 32'h06);
    rd(`OFS_STATUS, 32'h19);
    chk({GROUP_SEL, SETUP_EN}, 3'h5);
    aud(24'h000400, 96'h1000000C0000080000100);
    wr(`OFS_CONFIG, 32'h07);
    rd(`OFS_STATUS, 32'h0D);
    SDI_IS625 <= 1'b1;
    repeat (4) @(posedge MCLK);
    rd(`OFS_STATUS, 32'h0E);
    chk(SETUP_EN, 1'b0);
    SDI_LOCK <= 1'b0;
    repeat (4) @(posedge MCLK);
    rd(`OFS_STATUS, 32'h0C);
    aud(24'h100000, 96'h0, 1'b0);
    SDI_LOCK <= 1'b1;
    SDI_IS625 <= 1'b0;
    wr(`OFS_CONFIG, 32'hC0);
    // Select outputs follow the register one clock later
    @(posedge MCLK);
    chk({DIG_REF_SEL, ANLG_REF_SEL}, 2'h3);
    wr(`OFS_GAIN1, 32'hFFFFFFB0);
    rd(`OFS_GAIN1, 32'hFFFFFFBA);
    wr(`OFS_GAIN1, 32'h14);
    rd(`OFS_GAIN1, 32'h0C);
    wr(`OFS_DEFAULT, 32'h2);
    rd(`OFS_GAIN1, 32'h0);
    wr(6'h3C, 32'h1, 2'h2);
    rd(6'h3C, 32'h0, 2'h2);
    // Lock and group changes above left events pending
    wr(`OFS_IRQ_CLR, 32'h3F);
    wr(`OFS_IRQ_EN, 32'h04);
    rd(`OFS_IRQ_STAT, 32'h0);
    chk(IRQ, 1'b0);
    aud(24'h7FFFFF, 96'h4000003000002007FFFFF);
    rd(`OFS_IRQ_STAT, 32'h04);
    rd(`OFS_METER, 32'h006);
    chk(IRQ, 1'b1);
    wr(`OFS_IRQ_EN, 32'h0);
    // Interrupt line sees a new enable one clock after the write
    @(posedge MCLK);
    chk(IRQ, 1'b0);
    wr(`OFS_IRQ_EN, 32'h04);
    @(posedge MCLK);
    chk(IRQ, 1'b1);
    wr(`OFS_IRQ_CLR, 32'h04);
    chk(IRQ, 1'b0);
    rd(`OFS_IRQ_STAT, 32'h0);
    wr(`OFS_GAIN2, 32'h03);
    wr(`OFS_CTRL, 32'h20);
    rd(`OFS_GAIN3, 32'h03);
    // Mid-run reset drops pipeline, meters and settings
    RST_B <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_B <= 1'b1;
    chk(AUD_OUT.ch, 96'h0);
    chk(METER, 12'h000);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_GAIN2, 32'h0);
    chk(IRQ, 1'b0);
    summarize();
  end
endmodule

// ---- sim/sdi_rx_model.sv ----
// Receiver model: hands over the selected group's four samples
module sdi_rx_model (
  // Clock and control
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic [1:0]                     grp_sel,
  input  wire logic                           send,
  input  wire audio_mixer_pkg::sample_t [3:0] smp,
  // Extracted audio
  output audio_mixer_pkg::audio_frame_t       aud
);
  timeunit 1ns;
  timeprecision 100ps;

  audio_mixer_pkg::sample_t [3:0] last_r;

  // Each group gets its own scaling, so a wrong selection shows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aud <= '0;
      last_r <= '0;
    end else if (send) begin
      aud.valid <= 1'b1;
      for (int k = 0; k < 4; k++) begin
        aud.ch[k] <= smp[k] >>> grp_sel;
        last_r[k] <= smp[k] >>> grp_sel;
      end
    end else begin
      // Idle lines never hold the last sample
      aud.valid <= 1'b0;
      aud.ch <= ~last_r;
    end
  end
endmodule
